// *** verilog/host_port_device.sv ***
// device end of the parallel host port: pin decode, byte pairing, holders
//
// Contract
// - byte-wide bidirectional data bus to registers
// - release bus when disabled or not reading
// - holders keep last level when undriven (here only while unselected)
// - holders off at reset, control bit enables
// - data pins usable as general-purpose io
// - select inputs pick one of three registers
// - wide mode ignores select inputs
// - byte flag marks first or second byte
// - wide mode ignores byte flag
// - port ignored while select is high
// - strobes time capture and output
// - address strobe latches host address register
// - direction high reads, low writes
// - ready output, high during reset
// - active-low interrupt, high in reset
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module host_port_device #(
  parameter int ADDR_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  host_port_if.device            hp,
  input  wire logic              output_enable_n,
  input  wire logic              wide_host_mode,
  input  wire logic              gpio_mode,
  input  wire logic [7:0]        gpio_out,
  input  wire logic [7:0]        gpio_oe,
  output logic      [7:0]        gpio_in,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic                   mem_wr,
  output logic                   mem_rd,
  output logic      [15:0]       mem_wdata,
  input  wire logic [15:0]       mem_rdata,
  output logic      [15:0]       control_word,
  output logic                   data_holder_enable,
  input  wire logic              dsp_int_req
);
  initial begin
    if (ADDR_W < 1 || ADDR_W > 16) $error("ADDR_W must be 1..16");
  end

  logic [15:0]       control_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [7:0]        first_byte_ff;
  logic [15:0]       read_word_ff;
  logic [7:0]        rd_byte_ff;
  logic              rd_drive_ff;
  logic              strobe_d_ff;
  logic              ale_d_ff;
  logic [7:0]        hold_ff;
  logic              host_interrupt_n_ff;
  logic              mem_wr_ff;
  logic              mem_rd_ff;
  logic [15:0]       mem_wdata_ff;

  logic       strobe;
  logic       strobe_rise;
  logic       strobe_fall;
  logic       selected;
  logic [1:0] reg_sel;
  logic       second_byte;

  assign selected    = !hp.port_select_n;
  // active strobe is the low phase of either data strobe
  assign strobe      = selected && !(hp.transfer_strobe_a && hp.transfer_strobe_b);
  assign strobe_fall = strobe && !strobe_d_ff;
  assign strobe_rise = !strobe && strobe_d_ff;
  // wide mode: always the data register, no pairing
  assign reg_sel     = wide_host_mode ? host_port_pkg::SEL_DATA
                     : {hp.register_select_high, hp.register_select_low};
  assign second_byte = wide_host_mode ? 1'b0 : hp.byte_order_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_d_ff <= 1'b0;
      ale_d_ff    <= 1'b1;
    end else begin
      strobe_d_ff <= strobe;
      ale_d_ff    <= hp.address_strobe_n;
    end
  end

  // address latch on falling edge of address strobe, or write to address register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff <= '0;
    end else if (selected && ale_d_ff && !hp.address_strobe_n) begin
      addr_ff <= ADDR_W'({8'h00, hp.host_data_lines});
    end else if (strobe_rise && !hp.transfer_direction && second_byte
                 && reg_sel == host_port_pkg::SEL_ADDRESS) begin
      addr_ff <= ADDR_W'({first_byte_ff, hp.host_data_lines});
    end else if (strobe_rise && second_byte && reg_sel == host_port_pkg::SEL_DATA_INC) begin
      addr_ff <= addr_ff + ADDR_W'(1);
    end
  end

  // write path: capture at strobe end, pair bytes into words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_byte_ff <= 8'h00;
      control_ff    <= host_port_pkg::CTL_RESET;
      mem_wr_ff     <= 1'b0;
      mem_wdata_ff  <= 16'h0000;
    end else begin
      mem_wr_ff <= 1'b0;
      if (strobe_rise && !hp.transfer_direction) begin
        if (wide_host_mode) begin
          mem_wdata_ff <= {8'h00, hp.host_data_lines};
          mem_wr_ff    <= 1'b1;
        end else if (!second_byte) begin
          first_byte_ff <= hp.host_data_lines;
        end else if (reg_sel == host_port_pkg::SEL_CONTROL) begin
          control_ff <= {first_byte_ff, hp.host_data_lines};
        end else if (reg_sel != host_port_pkg::SEL_ADDRESS) begin
          mem_wdata_ff <= {first_byte_ff, hp.host_data_lines};
          mem_wr_ff    <= 1'b1;
        end
      end
    end
  end

  // read path: fetch word on first byte, present the addressed half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rd_ff    <= 1'b0;
      read_word_ff <= 16'h0000;
      rd_byte_ff   <= 8'h00;
      rd_drive_ff  <= 1'b0;
    end else begin
      mem_rd_ff   <= strobe_fall && hp.transfer_direction && !second_byte
                     && reg_sel[1];
      rd_drive_ff <= strobe && hp.transfer_direction;
      if (mem_rd_ff) begin
        read_word_ff <= mem_rdata;
      end
      case (reg_sel)
        host_port_pkg::SEL_CONTROL: rd_byte_ff <= second_byte ? control_ff[7:0] : control_ff[15:8];
        host_port_pkg::SEL_ADDRESS: rd_byte_ff <= 8'(addr_ff);
        default: rd_byte_ff <= second_byte ? read_word_ff[7:0]
                              : (mem_rd_ff ? mem_rdata[15:8] : read_word_ff[15:8]);
      endcase
    end
  end

  // interrupt: set by processor, cleared by host writing the control bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_interrupt_n_ff <= 1'b0;
    end else if (dsp_int_req) begin
      host_interrupt_n_ff <= 1'b1;
    end else if (strobe_rise && !hp.transfer_direction && second_byte
                 && reg_sel == host_port_pkg::SEL_CONTROL
                 && hp.host_data_lines[host_port_pkg::CTL_HOST_INTERRUPT_N_BIT]) begin
      host_interrupt_n_ff <= 1'b0;
    end
  end

  // holders remember last driven level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 8'h00;
    end else begin
      hold_ff <= hp.host_data_lines;
    end
  end

  logic bus_drive;
  logic bus_hold;
  assign data_holder_enable = control_ff[host_port_pkg::CTL_HOLD_BIT];
  assign bus_drive = output_enable_n && !gpio_mode && rd_drive_ff;
  // holders only while unselected, so they never fight the host
  assign bus_hold  = data_holder_enable && !selected && !bus_drive;
  assign hp.host_data_oe_dev   = !output_enable_n ? 1'b0
                               : gpio_mode ? (|gpio_oe)
                               : (bus_drive || bus_hold);
  assign hp.host_data_from_dev = gpio_mode ? gpio_out
                               : (bus_drive ? rd_byte_ff : hold_ff);
  assign gpio_in        = hp.host_data_lines;
  assign hp.port_ready_out   = !presetn || !(mem_rd_ff || mem_wr_ff);
  assign hp.host_interrupt_n = !presetn || wide_host_mode || !host_interrupt_n_ff;
  assign mem_addr     = addr_ff;
  assign mem_wr       = mem_wr_ff;
  assign mem_rd       = mem_rd_ff;
  assign mem_wdata    = mem_wdata_ff;
  assign control_word = control_ff;
endmodule
`default_nettype wire

// *** verilog/host_port_pkg.sv ***
// shared constants and types for the parallel host port
package host_port_pkg;
  // register select codes (two select inputs)
  localparam logic [1:0] SEL_CONTROL  = 2'h0;
  localparam logic [1:0] SEL_ADDRESS  = 2'h1;
  localparam logic [1:0] SEL_DATA_INC = 2'h2;
  localparam logic [1:0] SEL_DATA     = 2'h3;
  // register indices inside the device
  localparam logic [1:0] REG_CONTROL  = 2'h0;
  localparam logic [1:0] REG_ADDRESS  = 2'h1;
  localparam logic [1:0] REG_DATA     = 2'h2;
  // controller register byte offsets (apb)
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_WDATA    = 8'h04;
  localparam logic [7:0] OFF_RDATA    = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  // cmd register fields
  localparam int CMD_GO_BIT    = 0;
  localparam int CMD_READ_BIT  = 1;
  localparam int CMD_SEL_LSB   = 2;
  localparam int CMD_ALE_BIT   = 5;
  // irq bits
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_HOST_INTERRUPT_N_BIT  = 1;
  // device control register bits
  localparam int CTL_HOST_INTERRUPT_N_BIT  = 1;
  localparam int CTL_HOLD_BIT  = 3;
  // reset values
  localparam logic [15:0] CTL_RESET   = 16'h0000;
  localparam logic [31:0] MASK_RESET  = 32'h00000000;
  // strobe phase length in pclk cycles
  localparam int STROBE_CYCLES = 3;
  typedef enum logic [2:0] {H_IDLE, H_ALE, H_SETUP, H_STROBE, H_RECOVER} host_state_t;
endpackage

// *** verilog/host_port_if.sv ***
// pin-level carrier between host controller and host port
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
  logic [7:0] host_data_from_host;
  logic       host_data_oe_host;
  logic [7:0] host_data_from_dev;
  logic       host_data_oe_dev;
  logic [7:0] host_data_lines;
  logic       register_select_low;
  logic       register_select_high;
  logic       byte_order_flag;
  logic       port_select_n;
  logic       transfer_strobe_a;
  logic       transfer_strobe_b;
  logic       address_strobe_n;
  logic       transfer_direction;
  logic       port_ready_out;
  logic       host_interrupt_n;
  // resolved bus level seen by both ends
  assign host_data_lines = host_data_oe_dev  ? host_data_from_dev :
                           host_data_oe_host ? host_data_from_host : 8'hFF;
  modport host (
    output host_data_from_host, host_data_oe_host, register_select_low, register_select_high,
           byte_order_flag, port_select_n, transfer_strobe_a, transfer_strobe_b,
           address_strobe_n, transfer_direction,
    input  host_data_lines, port_ready_out, host_interrupt_n
  );
  modport device (
    output host_data_from_dev, host_data_oe_dev, port_ready_out, host_interrupt_n,
    input  host_data_lines, register_select_low, register_select_high, byte_order_flag,
           port_select_n, transfer_strobe_a, transfer_strobe_b, address_strobe_n,
           transfer_direction
  );
endinterface
`default_nettype wire

// *** verilog/host_port_host.sv ***
// host end: apb-programmed controller that drives the parallel port pins
`timescale 1ns/1ps
`default_nettype none
module host_port_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  host_port_if.host        hp
);
  host_port_pkg::host_state_t state_ff;
  logic [31:0] cmd_ff;
  logic [7:0]  wdata_ff;
  logic [7:0]  rdata_ff;
  logic [1:0]  irq_stat_ff;
  logic [1:0]  irq_mask_ff;
  logic [1:0]  cnt_ff;
  logic        host_interrupt_n_d_ff;
  logic        done_pulse;
  logic        wr_acc;
  logic        busy;

  assign wr_acc  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign busy    = state_ff != host_port_pkg::H_IDLE;
  assign pslverr = psel && penable && !(paddr inside {host_port_pkg::OFF_CMD, host_port_pkg::OFF_WDATA,
                   host_port_pkg::OFF_RDATA, host_port_pkg::OFF_STATUS,
                   host_port_pkg::OFF_IRQ_STAT, host_port_pkg::OFF_IRQ_MASK});

  always_comb begin
    case (paddr)
      host_port_pkg::OFF_CMD:      prdata = cmd_ff;
      host_port_pkg::OFF_WDATA:    prdata = {24'h000000, wdata_ff};
      host_port_pkg::OFF_RDATA:    prdata = {24'h000000, rdata_ff};
      host_port_pkg::OFF_STATUS:   prdata = {29'h00000000, !hp.host_interrupt_n, hp.port_ready_out, busy};
      host_port_pkg::OFF_IRQ_STAT: prdata = {30'h00000000, irq_stat_ff};
      host_port_pkg::OFF_IRQ_MASK: prdata = {30'h00000000, irq_mask_ff};
      default:                     prdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff   <= 32'h00000000;
      wdata_ff <= 8'h00;
      irq_mask_ff <= 2'h0;
    end else begin
      if (wr_acc && paddr == host_port_pkg::OFF_CMD && !busy) begin
        cmd_ff <= pwdata;
      end else if (state_ff == host_port_pkg::H_IDLE) begin
        cmd_ff[host_port_pkg::CMD_GO_BIT] <= 1'b0;
      end
      if (wr_acc && paddr == host_port_pkg::OFF_WDATA) begin
        wdata_ff <= pwdata[7:0];
      end
      if (wr_acc && paddr == host_port_pkg::OFF_IRQ_MASK) begin
        irq_mask_ff <= pwdata[1:0];
      end
    end
  end

  // transfer sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= host_port_pkg::H_IDLE;
      cnt_ff   <= 2'h0;
      rdata_ff <= 8'h00;
    end else begin
      case (state_ff)
        host_port_pkg::H_IDLE: begin
          if (cmd_ff[host_port_pkg::CMD_GO_BIT] && hp.port_ready_out) begin
            state_ff <= cmd_ff[host_port_pkg::CMD_ALE_BIT] ? host_port_pkg::H_ALE : host_port_pkg::H_SETUP;
          end
        end
        host_port_pkg::H_ALE:   state_ff <= host_port_pkg::H_SETUP;
        host_port_pkg::H_SETUP: begin
          state_ff <= host_port_pkg::H_STROBE;
          cnt_ff   <= 2'(host_port_pkg::STROBE_CYCLES - 1);
        end
        host_port_pkg::H_STROBE: begin
          if (cnt_ff == 2'h0) begin
            state_ff <= host_port_pkg::H_RECOVER;
            if (cmd_ff[host_port_pkg::CMD_READ_BIT]) begin
              rdata_ff <= hp.host_data_lines;
            end
          end else begin
            cnt_ff <= cnt_ff - 2'h1;
          end
        end
        host_port_pkg::H_RECOVER: state_ff <= host_port_pkg::H_IDLE;
        default: state_ff <= host_port_pkg::H_IDLE;
      endcase
    end
  end

  assign done_pulse = state_ff == host_port_pkg::H_RECOVER;

  // sticky status, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= 2'h0;
      host_interrupt_n_d_ff   <= 1'b0;
    end else begin
      host_interrupt_n_d_ff <= !hp.host_interrupt_n;
      irq_stat_ff <= (irq_stat_ff & ~((wr_acc && paddr == host_port_pkg::OFF_IRQ_STAT) ? pwdata[1:0] : 2'h0))
                   | {!hp.host_interrupt_n && !host_interrupt_n_d_ff, done_pulse};
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  logic in_xfer;
  assign in_xfer = state_ff != host_port_pkg::H_IDLE;
  assign hp.port_select_n        = !in_xfer;
  assign hp.register_select_low  = cmd_ff[host_port_pkg::CMD_SEL_LSB];
  assign hp.register_select_high = cmd_ff[host_port_pkg::CMD_SEL_LSB+1];
  assign hp.byte_order_flag      = cmd_ff[host_port_pkg::CMD_SEL_LSB+2];
  assign hp.transfer_direction   = cmd_ff[host_port_pkg::CMD_READ_BIT];
  assign hp.address_strobe_n     = state_ff != host_port_pkg::H_ALE;
  assign hp.transfer_strobe_a    = state_ff != host_port_pkg::H_STROBE;
  assign hp.transfer_strobe_b    = 1'b1;
  assign hp.host_data_from_host  = wdata_ff;
  assign hp.host_data_oe_host    = in_xfer && (!cmd_ff[host_port_pkg::CMD_READ_BIT]
                                   || state_ff == host_port_pkg::H_ALE);
endmodule
`default_nettype wire

// *** tb/host_port_monitor.sv ***
// concurrent checks on the pin interface between the two ends
`timescale 1ns/1ps
`default_nettype none
module host_port_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic host_data_oe_host,
  input wire logic host_data_oe_dev,
  input wire logic register_select_low,
  input wire logic register_select_high,
  input wire logic byte_order_flag,
  input wire logic port_select_n,
  input wire logic transfer_strobe_a,
  input wire logic transfer_strobe_b,
  input wire logic transfer_direction,
  input wire logic data_holder_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_no_contention: assert property (!(host_data_oe_dev && host_data_oe_host))
    else $error("both ends drive the data lines");
  chk_idle_released: assert property (port_select_n && $past(port_select_n) && !data_holder_enable
    |-> !host_data_oe_dev)
    else $error("device drives data while unselected");
  chk_read_drive: assert property (!transfer_strobe_a && $past(!transfer_strobe_a) && transfer_direction
    && !port_select_n |-> host_data_oe_dev) else $error("device silent during read strobe");
  chk_write_drive: assert property (!transfer_strobe_a && !transfer_direction |-> host_data_oe_host)
    else $error("host silent during write strobe");
  chk_strobe_selected: assert property ($fell(transfer_strobe_a) |-> !port_select_n)
    else $error("strobe without select");
  chk_strobe_width: assert property ($fell(transfer_strobe_a) |-> ##1 !transfer_strobe_a
    ##1 !transfer_strobe_a ##1 transfer_strobe_a)
    else $error("strobe width wrong");
  chk_unselected_quiet: assert property (port_select_n |-> transfer_strobe_a && transfer_strobe_b)
    else $error("strobe active while unselected");
  chk_fields_stable: assert property (!transfer_strobe_a && $past(!transfer_strobe_a) |->
    $stable(transfer_direction) && $stable(byte_order_flag) && $stable(register_select_low)
    && $stable(register_select_high)) else $error("access fields change in strobe");
  cov_read: cover property (!transfer_strobe_a && transfer_direction);
  cov_write: cover property (!transfer_strobe_a && !transfer_direction);
  cov_second_byte: cover property (!transfer_strobe_a && byte_order_flag);
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench joining host controller and device end
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, mem_wr, mem_rd, data_holder_enable;
  logic        dsp_int_req;
  logic [7:0]  paddr, gpio_in, hi, lo;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, control_word, wr_addr, wr_data;
  logic        e, wide, ale;
  int          miscompares = 0, n_checks = 0, wr_cnt = 0;
  host_port_if hp ();
  host_port_host i_host_port_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .hp(hp));
  host_port_device i_host_port_device (.pclk, .presetn, .hp(hp), .output_enable_n(1'b1), .wide_host_mode(wide),
    .gpio_mode(1'b0), .gpio_out(8'h00), .gpio_oe(8'h00), .gpio_in, .mem_addr, .mem_wr, .mem_rd, .mem_wdata,
    .mem_rdata, .control_word, .data_holder_enable, .dsp_int_req);
  host_port_monitor i_host_port_monitor (.pclk(pclk), .presetn(presetn), .host_data_oe_host(hp.host_data_oe_host),
    .host_data_oe_dev(hp.host_data_oe_dev), .register_select_low(hp.register_select_low),
    .register_select_high(hp.register_select_high), .byte_order_flag(hp.byte_order_flag),
    .port_select_n(hp.port_select_n), .transfer_strobe_a(hp.transfer_strobe_a),
    .transfer_strobe_b(hp.transfer_strobe_b), .transfer_direction(hp.transfer_direction),
    .data_holder_enable(data_holder_enable));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (mem_wr === 1'b1) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_of_test;
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one byte over the pins, polling busy until the controller is idle
  task xfer(input logic rd, input logic [1:0] sel, input logic flag, input logic [7:0] b, output logic [7:0] rb);
    int n;
    if (!rd) apb(1'b1, host_port_pkg::OFF_WDATA, {24'h0, b});
    apb(1'b1, host_port_pkg::OFF_CMD, {26'h0, ale, flag, sel, rd, 1'b1});
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 100) begin
      apb(1'b0, host_port_pkg::OFF_STATUS, 32'h0);
      n++;
    end
    check("xfer_done", n < 100, 1'b1);
    if (rd) apb(1'b0, host_port_pkg::OFF_RDATA, 32'h0);
    rb = r[7:0];
  endtask
  task word(input logic [1:0] sel, input logic [15:0] w);
    logic [7:0] unused;
    xfer(1'b0, sel, 1'b0, w[15:8], unused);
    xfer(1'b0, sel, 1'b1, w[7:0], unused);
  endtask
  task t_control;
    word(host_port_pkg::SEL_CONTROL, 16'h0008);
    check("control_word", control_word, 16'h0008);
    check("holder_on", data_holder_enable, 1'b1);
    word(host_port_pkg::SEL_CONTROL, 16'h0000);
    check("holder_off", data_holder_enable, 1'b0);
  endtask
  task t_mem_write;
    word(host_port_pkg::SEL_ADDRESS, 16'h1234);
    word(host_port_pkg::SEL_DATA, 16'hABCD);
    check("wr_addr", wr_addr, 16'h1234);
    check("wr_data", wr_data, 16'hABCD);
    check("wr_cnt", wr_cnt, 1);
  endtask
  task t_mem_read;
    mem_rdata <= 16'h5A3C;
    ale = 1'b1;
    xfer(1'b0, host_port_pkg::SEL_ADDRESS, 1'b0, 8'h77, hi);
    ale = 1'b0;
    check("ale_addr", mem_addr, 16'h0077);
    word(host_port_pkg::SEL_ADDRESS, 16'h0040);
    xfer(1'b1, host_port_pkg::SEL_DATA, 1'b0, 8'h00, hi);
    xfer(1'b1, host_port_pkg::SEL_DATA, 1'b1, 8'h00, lo);
    check("read_word", {hi, lo}, 16'h5A3C);
  endtask
  task t_wide;
    wide <= 1'b1;
    xfer(1'b0, host_port_pkg::SEL_CONTROL, 1'b1, 8'h66, hi);
    check("wide_wr_data", wr_data, 16'h0066);
    check("wide_wr_cnt", wr_cnt, 2);
    check("wide_ctl_kept", control_word, 16'h0000);
    wide <= 1'b0;
  endtask
  task t_apb_regs;
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped_err", e, 1'b1);
    apb(1'b0, host_port_pkg::OFF_IRQ_MASK, 32'h0);
    check("mask_reset", r, host_port_pkg::MASK_RESET);
    check("irq_masked", irq, 1'b0);
  endtask
  task t_irq;
    apb(1'b1, host_port_pkg::OFF_IRQ_MASK, 32'h2);
    dsp_int_req <= 1'b1;
    @(posedge pclk);
    dsp_int_req <= 1'b0;
    repeat (3) @(posedge pclk);
    check("host_interrupt_n_low", hp.host_interrupt_n, 1'b0);
    check("irq_high", irq, 1'b1);
    word(host_port_pkg::SEL_CONTROL, 16'h0002);
    check("host_interrupt_n_clear", hp.host_interrupt_n, 1'b1);
    apb(1'b1, host_port_pkg::OFF_IRQ_STAT, 32'h3);
    apb(1'b0, host_port_pkg::OFF_IRQ_STAT, 32'h0);
    check("irq_stat", r[1:0], 2'h0);
    check("irq_low", irq, 1'b0);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, dsp_int_req} = 4'h0;
    wide = 1'b0;
    ale = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mem_rdata = 16'h0000;
    repeat (4) @(posedge pclk);
    check("ready_in_reset", hp.port_ready_out, 1'b1);
    check("host_interrupt_n_in_reset", hp.host_interrupt_n, 1'b1);
    check("holder_reset", data_holder_enable, 1'b0);
    check("ctl_reset", control_word, host_port_pkg::CTL_RESET);
    check("idle_select", hp.port_select_n, 1'b1);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_control;
    t_mem_write;
    t_mem_read;
    t_wide;
    t_apb_regs;
    t_irq;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_of_test;
  end
endmodule
`default_nettype wire
